// [logic/card_cfg_pkg.sv]
// shared constants and types of the card configuration register bank
`default_nettype none
package card_cfg_pkg;

  // attribute addresses of the configuration registers (byte addresses, even only)
  localparam logic [10:0] OFS_OPTION     = 11'h200;
  localparam logic [10:0] OFS_STATUS     = 11'h202;
  localparam logic [10:0] OFS_PINREP     = 11'h204;
  localparam logic [1:0]  CFG_SPACE_HI   = 2'h1;

  // option register layout
  localparam int          OPT_SRST_BIT   = 7;
  localparam int          OPT_LEVEL_BIT  = 6;
  localparam int          OPT_INDEX_MSB  = 5;
  localparam logic [5:0]  INDEX_RESET    = 6'h00;

  // status register layout
  localparam int          STS_CHANGED    = 7;
  localparam int          STS_STATUS_CHANGE_ENABLE     = 6;
  localparam int          STS_IO8        = 5;
  localparam int          STS_POWER_DOWN_REQUEST     = 2;
  localparam int          STS_INT        = 1;

  // pin replacement layout
  localparam int          PR_RDY_CHG     = 5;
  localparam int          PR_WP_CHG      = 4;
  localparam int          PR_ONE_HI      = 3;
  localparam int          PR_ONE_LO      = 2;
  localparam int          PR_RAW_RDY     = 1;
  localparam int          PR_RAW_WP      = 0;

  // configuration index codes
  localparam logic [5:0]  CFG_MEM        = 6'h00;
  localparam logic [5:0]  CFG_IO_ANY     = 6'h01;
  localparam logic [5:0]  CFG_IO_PRI     = 6'h02;
  localparam logic [5:0]  CFG_IO_SEC     = 6'h03;

  // timing
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          PWR_SETTLE_NS  = 1000;
  localparam int          PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          AUTO_SLEEP_NS  = 5000000;
  localparam int          AUTO_SLEEP_CYC = AUTO_SLEEP_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    MODE_MEM    = 4'b0001,
    MODE_IO_ANY = 4'b0010,
    MODE_IO_PRI = 4'b0100,
    MODE_IO_SEC = 4'b1000
  } card_mode_t;

  typedef enum logic [3:0] {
    PWR_ACTIVE    = 4'b0001,
    PWR_TO_SAVE   = 4'b0010,
    PWR_SAVE      = 4'b0100,
    PWR_TO_ACTIVE = 4'b1000
  } pwr_state_t;

  typedef struct packed {
    logic        reg_n;
    logic        ce1_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
    logic [7:0]  data;
    logic        hw_reset;
  } pin_bus_t;

endpackage
`default_nettype wire

// [logic/card_power_ctrl.sv]
// power state sequencer: requested power-down, automatic sleep and ready tracking
`timescale 1ns/1ps
`default_nettype none
module card_power_ctrl #(
  parameter int AUTO_SLEEP_CYC = card_cfg_pkg::AUTO_SLEEP_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_sync_rst,
  input  wire logic i_power_down_request,
  input  wire logic i_idle,
  input  wire logic i_cmd_start,
  output logic      o_ready,
  output logic      o_power_save
);
  import card_cfg_pkg::*;

  pwr_state_t  state;
  pwr_state_t  next_state;
  logic        req_prev;
  logic [7:0]  settle_cnt;
  logic [23:0] idle_cnt;
  logic        auto_sleep;
  logic [7:0]  quiet_cnt;
  wire         req_changed  = (i_power_down_request != req_prev);
  wire         settle_done  = (settle_cnt == 8'(PWR_SETTLE_CYC - 1));
  wire         idle_expired = (idle_cnt == 24'(AUTO_SLEEP_CYC - 1));
  wire         in_transit   = (state == PWR_TO_SAVE) || (state == PWR_TO_ACTIVE);

  always_comb begin
    next_state = state;
    case (state)
      // level compare, so a request undone mid-transit turns the transit back when it settles
      PWR_ACTIVE:    if (i_power_down_request) next_state = PWR_TO_SAVE;
      PWR_TO_SAVE:   if (settle_done) next_state = i_power_down_request ? PWR_SAVE : PWR_TO_ACTIVE;
      PWR_SAVE:      if (!i_power_down_request) next_state = PWR_TO_ACTIVE;
      PWR_TO_ACTIVE: if (settle_done) next_state = i_power_down_request ? PWR_TO_SAVE : PWR_ACTIVE;
      default:       next_state = PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state      <= PWR_ACTIVE;
      req_prev   <= 1'b0;
      settle_cnt <= 8'h00;
    end else if (i_sync_rst) begin
      state      <= PWR_ACTIVE;
      req_prev   <= 1'b0;
      settle_cnt <= 8'h00;
    end else begin
      state      <= next_state;
      req_prev   <= i_power_down_request;
      settle_cnt <= (in_transit && !settle_done) ? settle_cnt + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_cnt   <= 24'h000000;
      auto_sleep <= 1'b0;
    end else if (i_sync_rst || i_cmd_start || !i_idle) begin
      idle_cnt   <= 24'h000000;
      auto_sleep <= 1'b0;
    end else if (idle_expired) begin
      auto_sleep <= 1'b1;
    end else begin
      idle_cnt   <= idle_cnt + 24'h000001;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready      <= 1'b0;
      o_power_save <= 1'b0;
    end else begin
      o_ready      <= !i_sync_rst && !req_changed && ((next_state == PWR_ACTIVE) || (next_state == PWR_SAVE));
      o_power_save <= (next_state == PWR_SAVE) || auto_sleep;
    end
  end

  // check helper: cycles since the last request flip, saturating
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      quiet_cnt <= 8'h00;
    end else if (req_changed || i_sync_rst) begin
      quiet_cnt <= 8'h00;
    end else if (quiet_cnt != 8'hFF) begin
      quiet_cnt <= quiet_cnt + 8'h01;
    end
  end

  sequence s_req_flip;
    !i_sync_rst && req_changed;
  endsequence
  sequence s_busy_run;
    !o_ready [*8];
  endsequence
  property p_busy_on_change;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_req_flip |=> s_busy_run;
  endproperty
  a_busy_on_change: assert property (p_busy_on_change) else $error("ready shown during power change");
  property p_ready_bounded;
    @(posedge i_clk) disable iff (!i_arst_n || i_sync_rst)
    (quiet_cnt == 8'(2 * PWR_SETTLE_CYC + 8)) |-> o_ready;
  endproperty
  a_ready_bounded: assert property (p_ready_bounded) else $error("power state never reached");
  property p_save_entered;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state == PWR_SAVE) |-> o_power_save;
  endproperty
  a_save_entered: assert property (p_save_entered) else $error("power save not shown");

endmodule
`default_nettype wire

// [logic/card_config_status_registers.sv]
// card configuration option, status and change bits reached over attribute cycles
// Functional notes
// - option register at 200h: soft reset bit 7, irq mode bit 6, index bits 5-0.
// - soft reset bit set acts as hardware reset; bit itself stays set.
// - after soft reset bit clears, card sits unconfigured as after power-up.
// - soft reset from option register is a hard reset for the command layer.
// - irq mode bit 1 selects level, 0 pulse; cleared by any reset.
// - index 0 memory, 1 any I/O boundary, 2 primary, 3 secondary I/O.
// - status register at 202h; read bits 7,6,5,2,1; writable bits 6,5,2.
// - change summary reads 1 when ready-changed or write-protect-changed is set.
// - status-changed pin low when summary, enable set and I/O configured.
// - status-changed pin held high in I/O mode with enable clear.
// - eight-bit I/O request stored but ignored; both widths supported.
// - power-down request 1 enters power save, 0 enters active.
// - power-down request change forces busy until power state is reached.
// - card sleeps on idle and wakes on a command unless a set power-down request holds it in save.
// - interrupt status bit mirrors internal request in every mode.
// - interrupt status bit reads 0 while interrupts are disabled.
// - attribute accesses are byte wide at even addresses, low lane only.
// - ready-changed bit set whenever raw ready state changes outside reset.
`timescale 1ns/1ps
`default_nettype none
module card_config_status_registers #(
  parameter int AUTO_SLEEP_CYC = card_cfg_pkg::AUTO_SLEEP_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_hw_reset,
  input  wire logic              i_reg_n,
  input  wire logic              i_ce1_n,
  input  wire logic              i_oe_n,
  input  wire logic              i_we_n,
  input  wire logic [10:0]       i_addr,
  input  wire logic [7:0]        i_data,
  input  wire logic              i_irq_request,
  input  wire logic              i_interrupt_disable_bit,
  input  wire logic              i_core_ready,
  input  wire logic              i_idle,
  input  wire logic              i_cmd_start,
  output logic [7:0]             o_data,
  output logic                   o_data_oe,
  output logic                   o_status_changed_pin_n,
  output logic                   o_ready_busy,
  output logic                   o_core_hard_reset,
  output logic                   o_level_irq_select,
  output card_cfg_pkg::card_mode_t o_mode,
  output logic                   o_io_configured,
  output logic                   o_power_save
);
  import card_cfg_pkg::*;

  // pin synchroniser: stage one is read by stage two only
  pin_bus_t pin_raw;
  pin_bus_t pin_s1;
  pin_bus_t pin_s2;
  logic     we_s3;
  logic [7:0] wdata_hold;

  assign pin_raw = '{reg_n: i_reg_n, ce1_n: i_ce1_n, oe_n: i_oe_n, we_n: i_we_n,
                     addr: i_addr, data: i_data, hw_reset: i_hw_reset};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1 <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 11'h000, data: 8'h00, hw_reset: 1'b1};
      pin_s2 <= '{reg_n: 1'b1, ce1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 11'h000, data: 8'h00, hw_reset: 1'b1};
      we_s3  <= 1'b1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      we_s3  <= pin_s2.we_n;
    end
  end

  // data may drop right after the strobe rises, so keep what stood while it was low
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wdata_hold <= 8'h00;
    end else if (!pin_s2.we_n) begin
      wdata_hold <= pin_s2.data;
    end
  end

  // register state
  logic       soft_reset_bit;
  logic       level_irq_select;
  logic [5:0] config_index;
  logic       status_change_enable;
  logic       eight_bit_io_request;
  logic       power_down_request;
  logic       ready_changed;
  logic       write_protect_changed;
  logic       raw_ready_state;
  logic       int_status;
  logic       pwr_ready;
  logic       pwr_save;

  wire        attr_sel   = !pin_s2.reg_n && !pin_s2.ce1_n && !pin_s2.addr[0] &&
                           (pin_s2.addr[10:9] == CFG_SPACE_HI) && (pin_s2.addr[8:4] == 5'h00);
  wire        sel_option = attr_sel && (pin_s2.addr == OFS_OPTION);
  wire        sel_status = attr_sel && (pin_s2.addr == OFS_STATUS);
  wire        sel_pinrep = attr_sel && (pin_s2.addr == OFS_PINREP);
  wire        wr_strobe  = pin_s2.we_n && !we_s3;
  wire        wr_option  = wr_strobe && sel_option;
  wire        wr_status  = wr_strobe && sel_status;
  wire        wr_pinrep  = wr_strobe && sel_pinrep;
  wire        rd_active  = (sel_option || sel_status || sel_pinrep) && !pin_s2.oe_n && pin_s2.we_n;
  wire        hw_rst     = pin_s2.hw_reset;
  wire        sync_rst   = hw_rst || soft_reset_bit;
  wire        cfg_clear  = sync_rst || (wr_option && wdata_hold[OPT_SRST_BIT]);
  wire        changed    = ready_changed || write_protect_changed;
  wire        next_raw   = !sync_rst && pwr_ready && i_core_ready;

  card_mode_t mode_dec;
  assign mode_dec = (config_index == CFG_IO_ANY) ? MODE_IO_ANY :
                    (config_index == CFG_IO_PRI) ? MODE_IO_PRI :
                    (config_index == CFG_IO_SEC) ? MODE_IO_SEC : MODE_MEM;
  wire        io_cfg     = (mode_dec != MODE_MEM);

  // soft reset bit survives its own reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_reset_bit <= 1'b0;
    end else if (hw_rst) begin
      soft_reset_bit <= 1'b0;
    end else if (wr_option) begin
      soft_reset_bit <= wdata_hold[OPT_SRST_BIT];
    end
  end

  // option fields cleared on any reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_irq_select <= 1'b0;
      config_index     <= INDEX_RESET;
    end else if (cfg_clear) begin
      level_irq_select <= 1'b0;
      config_index     <= INDEX_RESET;
    end else if (wr_option) begin
      level_irq_select <= wdata_hold[OPT_LEVEL_BIT];
      config_index     <= wdata_hold[OPT_INDEX_MSB:0];
    end
  end

  // only the writable status bits load
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_change_enable <= 1'b0;
      eight_bit_io_request <= 1'b0;
      power_down_request   <= 1'b0;
    end else if (sync_rst) begin
      status_change_enable <= 1'b0;
      eight_bit_io_request <= 1'b0;
      power_down_request   <= 1'b0;
    end else if (wr_status) begin
      status_change_enable <= wdata_hold[STS_STATUS_CHANGE_ENABLE];
      eight_bit_io_request <= wdata_hold[STS_IO8];
      power_down_request   <= wdata_hold[STS_POWER_DOWN_REQUEST];
    end
  end

  // ready change detect, set beats host clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      raw_ready_state       <= 1'b0;
      ready_changed         <= 1'b0;
      write_protect_changed <= 1'b0;
    end else begin
      raw_ready_state <= next_raw;
      if (sync_rst) begin
        ready_changed <= 1'b0;
      end else if (next_raw != raw_ready_state) begin
        ready_changed <= 1'b1;
      end else if (wr_pinrep && wdata_hold[PR_RAW_RDY]) begin
        ready_changed <= wdata_hold[PR_RDY_CHG];
      end
      if (sync_rst) begin
        write_protect_changed <= 1'b0;
      end else if (wr_pinrep && wdata_hold[PR_RAW_WP]) begin
        write_protect_changed <= wdata_hold[PR_WP_CHG];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_status <= 1'b0;
    end else begin
      int_status <= i_irq_request && !i_interrupt_disable_bit;
    end
  end

  // read data: unused positions stay zero, pin replacement bits 3 and 2 read one
  logic [7:0] rd_option;
  logic [7:0] rd_status;
  logic [7:0] rd_pinrep;
  logic [7:0] rd_mux;
  always_comb begin
    rd_option = {soft_reset_bit, level_irq_select, config_index};
    rd_status = 8'h00;
    rd_status[STS_CHANGED] = changed;
    rd_status[STS_STATUS_CHANGE_ENABLE]  = status_change_enable;
    rd_status[STS_IO8]     = eight_bit_io_request;
    rd_status[STS_POWER_DOWN_REQUEST]  = power_down_request;
    rd_status[STS_INT]     = int_status;
    rd_pinrep = 8'h00;
    rd_pinrep[PR_RDY_CHG]  = ready_changed;
    rd_pinrep[PR_WP_CHG]   = write_protect_changed;
    rd_pinrep[PR_ONE_HI]   = 1'b1;
    rd_pinrep[PR_ONE_LO]   = 1'b1;
    rd_pinrep[PR_RAW_RDY]  = raw_ready_state;
    rd_pinrep[PR_RAW_WP]   = 1'b0;
    rd_mux = sel_option ? rd_option : sel_status ? rd_status : sel_pinrep ? rd_pinrep : 8'h00;
  end

  // outputs, all registered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data                 <= 8'h00;
      o_data_oe              <= 1'b0;
      o_status_changed_pin_n <= 1'b1;
      o_ready_busy           <= 1'b0;
      o_core_hard_reset      <= 1'b1;
      o_level_irq_select     <= 1'b0;
      o_mode                 <= MODE_MEM;
      o_io_configured        <= 1'b0;
      o_power_save           <= 1'b0;
    end else begin
      o_data                 <= rd_active ? rd_mux : 8'h00;
      o_data_oe              <= rd_active;
      o_status_changed_pin_n <= !(changed && status_change_enable && io_cfg);
      o_ready_busy           <= raw_ready_state;
      o_core_hard_reset      <= sync_rst;
      o_level_irq_select     <= level_irq_select;
      o_mode                 <= mode_dec;
      o_io_configured        <= io_cfg;
      o_power_save           <= pwr_save;
    end
  end

  card_power_ctrl #(
    .AUTO_SLEEP_CYC(AUTO_SLEEP_CYC)
  ) u_power (
    .i_clk                (i_clk),
    .i_arst_n             (i_arst_n),
    .i_sync_rst           (sync_rst),
    .i_power_down_request (power_down_request),
    .i_idle               (i_idle),
    .i_cmd_start          (i_cmd_start),
    .o_ready              (pwr_ready),
    .o_power_save         (pwr_save)
  );

  sequence s_status_read;
    rd_active && sel_status;
  endsequence
  sequence s_opt_write_srst;
    wr_option && wdata_hold[OPT_SRST_BIT] && !hw_rst;
  endsequence

  property p_soft_reset_holds;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_opt_write_srst |=> (soft_reset_bit ##1 (o_core_hard_reset && config_index == 6'h00));
  endproperty
  a_soft_reset_holds: assert property (p_soft_reset_holds) else $error("soft reset not applied");
  property p_unconfigured_after;
    @(posedge i_clk) disable iff (!i_arst_n)
    $fell(soft_reset_bit) |-> (!level_irq_select && config_index == 6'h00 && !power_down_request);
  endproperty
  a_unconfigured_after: assert property (p_unconfigured_after) else $error("not unconfigured after reset");
  property p_core_reset;
    @(posedge i_clk) disable iff (!i_arst_n)
    soft_reset_bit |=> o_core_hard_reset;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("command layer reset missing");
  property p_level_cleared;
    @(posedge i_clk) disable iff (!i_arst_n)
    hw_rst |=> (!level_irq_select ##1 !o_level_irq_select);
  endproperty
  a_level_cleared: assert property (p_level_cleared) else $error("irq mode bit survived reset");
  property p_decode_primary;
    @(posedge i_clk) disable iff (!i_arst_n)
    (config_index == 6'h02) |=> (o_mode == MODE_IO_PRI && o_io_configured);
  endproperty
  a_decode_primary: assert property (p_decode_primary) else $error("primary decode wrong");
  property p_status_read;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_status_read |=> (o_data_oe && o_data[STS_CHANGED] == $past(changed) && o_data[4:3] == 2'h0 && !o_data[0]);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read value wrong");
  property p_status_changed_pin_low;
    @(posedge i_clk) disable iff (!i_arst_n)
    (changed && status_change_enable && io_cfg) |=> !o_status_changed_pin_n;
  endproperty
  a_status_changed_pin_low: assert property (p_status_changed_pin_low) else $error("status-changed pin not low");
  property p_status_changed_pin_high;
    @(posedge i_clk) disable iff (!i_arst_n)
    (io_cfg && !status_change_enable) |=> o_status_changed_pin_n;
  endproperty
  a_status_changed_pin_high: assert property (p_status_changed_pin_high) else $error("status-changed pin not high");
  property p_int_masked;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_interrupt_disable_bit |=> !int_status;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("interrupt bit not masked");
  property p_int_follows;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_irq_request && !i_interrupt_disable_bit) |=> int_status;
  endproperty
  a_int_follows: assert property (p_int_follows) else $error("interrupt bit not following");
  property p_ready_changed_set;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!sync_rst && next_raw != raw_ready_state) |=> ready_changed;
  endproperty
  a_ready_changed_set: assert property (p_ready_changed_set) else $error("ready change lost");
  property p_hw_clears_soft;
    @(posedge i_clk) disable iff (!i_arst_n)
    hw_rst |=> !soft_reset_bit;
  endproperty
  a_hw_clears_soft: assert property (p_hw_clears_soft) else $error("soft reset bit survived pin reset");
  property p_option_read;
    @(posedge i_clk) disable iff (!i_arst_n)
    (rd_active && sel_option) |=> (o_data_oe && o_data[OPT_SRST_BIT] == $past(soft_reset_bit) &&
                                   o_data[OPT_INDEX_MSB:0] == $past(config_index));
  endproperty
  a_option_read: assert property (p_option_read) else $error("option read value wrong");
  property p_odd_refused;
    @(posedge i_clk) disable iff (!i_arst_n)
    (!pin_s2.reg_n && pin_s2.addr[0]) |=> !o_data_oe;
  endproperty
  a_odd_refused: assert property (p_odd_refused) else $error("odd attribute address driven");

endmodule
`default_nettype wire

// [test/host_model.sv]
// host socket model running attribute byte cycles on the card pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_data_oe,
  output logic             o_reg_n,
  output logic             o_ce1_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic [10:0]      o_addr,
  output logic [7:0]       o_data,
  output logic             o_done,
  output logic [8:0]       o_rdata
);
  initial begin
    {o_reg_n, o_ce1_n, o_oe_n, o_we_n} = 4'hF;
    o_addr = 11'h7FF;
    o_data = 8'hFF;
    o_done = 1'b0;
    o_rdata = 9'h000;
  end
  task automatic cyc(input logic wr, input logic [10:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_reg_n, o_ce1_n} <= 2'h0;
    o_addr <= a;
    o_data <= wr ? d : ~o_data;
    o_we_n <= !wr;
    o_oe_n <= wr;
    if (wr) begin
      repeat (4) @(posedge i_clk);
      o_we_n <= 1'b1;
    end else begin
      // refused reads never drive, so the wait is bounded
      repeat (8) begin
        @(posedge i_clk);
        if (i_data_oe === 1'b1) break;
      end
      o_rdata <= {i_data_oe, i_data};
      o_done <= 1'b1;
      o_oe_n <= 1'b1;
      @(posedge i_clk);
      o_done <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    // released lines show a changing pattern, not the last value
    {o_reg_n, o_ce1_n} <= 2'h3;
    o_addr <= ~a;
    o_data <= ~o_data;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench of the card configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import card_cfg_pkg::*;
  logic clk, arst_n, irq, dis, rdy, idle, cmd, reg_n, ce1_n, oe_n, we_n, done, hw;
  logic [10:0] addr;
  logic [7:0] hd, dd, seed;
  logic [8:0] rdata;
  logic oe, pin_n, busy, hrst, lvl, iocfg, psave;
  card_mode_t mode;
  logic [8:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  host_model h (.i_clk(clk), .i_data(dd), .i_data_oe(oe), .o_reg_n(reg_n), .o_ce1_n(ce1_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_addr(addr), .o_data(hd), .o_done(done), .o_rdata(rdata));
  card_config_status_registers #(.AUTO_SLEEP_CYC(20)) dut (.i_clk(clk), .i_arst_n(arst_n), .i_hw_reset(hw),
    .i_reg_n(reg_n), .i_ce1_n(ce1_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_data(hd),
    .i_irq_request(irq), .i_interrupt_disable_bit(dis), .i_core_ready(rdy), .i_idle(idle),
    .i_cmd_start(cmd), .o_data(dd), .o_data_oe(oe), .o_status_changed_pin_n(pin_n), .o_ready_busy(busy),
    .o_core_hard_reset(hrst), .o_level_irq_select(lvl), .o_mode(mode), .o_io_configured(iocfg),
    .o_power_save(psave));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    h.cyc(1'b1, a, d);
  endtask
  task automatic rd(input logic [10:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    h.cyc(1'b0, a, 8'h00);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) chk("read data", exp_q.pop_front(), rdata);
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {arst_n, irq, dis, idle, cmd, hw} = 6'h00;
    rdy = 1'b1;
    seed = 8'h4E;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_PINREP, 8'h03);
    rd(OFS_OPTION, 9'h100);
    rd(OFS_STATUS, 9'h100);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_OPTION, 8'h40 | 8'(i));
      rd(OFS_OPTION, 9'h140 | 9'(i));
      chk("mode", 9'(1 << i), 9'(mode));
      chk("io configured", 9'(i != 0), 9'(iocfg));
      chk("level irq", 9'h001, 9'(lvl));
    end
    $display("test index codes done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFS_STATUS, seed & 8'hFB);
      rd(OFS_STATUS, 9'h100 | 9'(seed & 8'h60));
    end
    $display("test status writes done");
    wr(OFS_STATUS, 8'h40);
    rdy <= 1'b0;
    repeat (3) @(posedge clk);
    rdy <= 1'b1;
    repeat (6) @(posedge clk);
    chk("status pin", 9'h000, 9'(pin_n));
    rd(OFS_STATUS, 9'h1C0);
    wr(OFS_STATUS, 8'h00);
    chk("status pin", 9'h001, 9'(pin_n));
    wr(OFS_PINREP, 8'h03);
    irq <= 1'b1;
    rd(OFS_STATUS, 9'h102);
    dis <= 1'b1;
    rd(OFS_STATUS, 9'h100);
    {irq, dis} <= 2'h0;
    $display("test change and interrupt done");
    wr(OFS_STATUS, 8'h04);
    chk("ready", 9'h000, 9'(busy));
    repeat (60) @(posedge clk);
    chk("power save", 9'h001, 9'(psave));
    chk("ready", 9'h001, 9'(busy));
    wr(OFS_STATUS, 8'h00);
    repeat (60) @(posedge clk);
    chk("power save", 9'h000, 9'(psave));
    idle <= 1'b1;
    repeat (40) @(posedge clk);
    chk("power save", 9'h001, 9'(psave));
    cmd <= 1'b1;
    idle <= 1'b0;
    repeat (4) @(posedge clk);
    cmd <= 1'b0;
    chk("power save", 9'h000, 9'(psave));
    $display("test power done");
    wr(OFS_OPTION, 8'h80);
    chk("hard reset", 9'h001, 9'(hrst));
    rd(OFS_OPTION, 9'h180);
    wr(OFS_OPTION, 8'h00);
    chk("mode", 9'(MODE_MEM), 9'(mode));
    chk("hard reset", 9'h000, 9'(hrst));
    wr(11'h201, 8'h43);
    rd(OFS_OPTION, 9'h100);
    rd(11'h201, 9'h000);
    $display("test soft reset and refusal done");
    wr(OFS_OPTION, 8'h42);
    hw <= 1'b1;
    repeat (4) @(posedge clk);
    hw <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_OPTION, 9'h100);
    chk("level irq", 9'h000, 9'(lvl));
    chk("mode", 9'(MODE_MEM), 9'(mode));
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
